/* File: rtl/spdp_bank.sv */
// configuration and status register bank of the single-pin debug port
// assumes the link instruction decoder, phy and access layer share clock_i
`timescale 1ns/1ps

// Behaviour
// - bank reachable only by debug instructions
// - phy registers 0x0-0x3, access 0x4-0xC
// - revision read-only at bits 7:4
// - error signature loaded on error, read clears
// - codes 1 parity, 2 stop, 4 start
// - code 3 timeout, 7 contention, 5-6 reserved
// - inter-byte gap of two idle characters
// - parity ignore suppresses parity errors
// - access response within 65536 cycles else timeout
// - response signature off stops response signatures
// - guard time 128 down to 2, 7 none
// - nack off suppresses reset-time nack
// - collision detection while disable bit is zero
// - port disable resets settings, keys, clock request
// - bit 5 reads user-row key active
// - bit 4 program key, cleared on done
// - reset signature holds system reset, bit 0
// - bit 3 erase key, cleared on done
// - clock request held until cleared or disabled
module spdp_bank
  import spdp_pkg::*;
#(
  parameter int BAUD_DIV = 25, // port clock cycles per link bit
  parameter int TIMEOUT_CYCLES = `SPDP_TIMEOUT_CYCLES, // access layer response limit
  parameter logic [3:0] PORT_REV = 4'h3 // arbitrary revision value
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register access from the link instruction decoder
  input wire spdp_acc_type acc_i,
  output logic [7:0] acc_rdata_o,
  output logic acc_rvalid_o,
  // phy events and handshakes
  input wire spdp_err_type err_i,
  input wire logic tx_active_i,
  input wire logic rx_to_tx_i,
  input wire logic tx_byte_done_i,
  input wire logic multi_byte_i,
  input wire logic resp_wait_i,
  input wire logic acc_resp_i,
  input wire logic nack_req_i,
  input wire logic link_wake_i,
  // key and system events from the access layer
  input wire logic key_urow_set_i,
  input wire logic key_prog_set_i,
  input wire logic key_erase_set_i,
  input wire logic prog_done_i,
  input wire logic erase_done_i,
  input wire logic sys_reset_active_i,
  input wire logic sys_sleep_i,
  input wire logic prog_ready_i,
  input wire logic urow_ready_i,
  input wire logic dev_locked_i,
  input wire logic [2:0] crc_status_i,
  // controls towards phy and system
  output logic tx_hold_o,
  output logic parity_check_en_o,
  output logic resp_sig_en_o,
  output logic collision_detect_en_o,
  output logic nack_send_o,
  output logic timeout_o,
  output logic phy_enable_o,
  output logic phy_reset_o,
  output logic sys_reset_req_o,
  output logic sys_clock_req_o,
  output logic urow_final_o,
  output logic [2:0] key_status_o
);

  localparam int GAP_BITS = `SPDP_IDLE_CHARS * `SPDP_CHAR_BITS;
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int DW = $clog2(BAUD_DIV + 1);

  // refuse settings the counters cannot serve
  if (BAUD_DIV < 1 || TIMEOUT_CYCLES < 2) begin : g_bad_params
    $error("spdp_bank: BAUD_DIV must be >= 1 and TIMEOUT_CYCLES >= 2");
  end

  // all state of the bank
  typedef struct packed {
    logic [7:0] ctrl_pri; // primary link control
    logic nack_off; // nack suppression
    logic coll_off; // collision detection disable
    logic [2:0] err_sig; // error signature
    logic [2:0] keys; // user row, program, erase keys
    logic rst_held; // system reset held by signature
    logic clk_req; // system clock request
    logic rstsys; // sticky system reset seen
    logic port_off; // phy disabled
    logic [7:0] rdata; // read data
    logic rvalid; // read answer pulse
    logic [TW-1:0] tmo_cnt; // response wait counter
    logic timeout; // timeout pulse
    logic [DW-1:0] div_cnt; // bit tick divider
    logic [7:0] gap_cnt; // remaining spacing bits
    spdp_tx_type tx_st; // transmitter spacing state
    logic phy_rst; // phy reset pulse
    logic urow_final; // user row final pulse
    logic nack; // nack pulse
  } spdp_state_type;

  spdp_state_type st_r;
  spdp_state_type st_nxt;

  // guard time in bit periods: code n gives 128 >> n
  function automatic logic [7:0] guard_bits(input logic [2:0] sel);
    guard_bits = `SPDP_GUARD_BASE >> sel;
  endfunction

  // read mux; unmapped and reserved bits return zero
  function automatic logic [7:0] read_mux(input spdp_state_type s, input logic [3:0] a, input logic [7:0] sys_st,
                                          input logic [2:0] crc);
    read_mux = 8'h00;
    case (a)
      `SPDP_OFS_REV_STATUS: read_mux = {PORT_REV, 4'h0};
      `SPDP_OFS_ERR_STATUS: read_mux = {5'h00, s.err_sig};
      `SPDP_OFS_CTRL_PRI: read_mux = s.ctrl_pri;
      `SPDP_OFS_CTRL_SEC: begin
        read_mux[`SPDP_BIT_NACK_OFF] = s.nack_off;
        read_mux[`SPDP_BIT_COLL_OFF] = s.coll_off;
      end
      `SPDP_OFS_KEY_STATUS: begin
        read_mux[`SPDP_BIT_KEY_UROW] = s.keys[2];
        read_mux[`SPDP_BIT_KEY_PROG] = s.keys[1];
        read_mux[`SPDP_BIT_KEY_ERASE] = s.keys[0];
      end
      `SPDP_OFS_RST_REQ: read_mux[`SPDP_BIT_RST_HELD] = s.rst_held;
      `SPDP_OFS_SYS_CTRL: read_mux[`SPDP_BIT_SYSTEM_CLOCK_REQUEST] = s.clk_req;
      `SPDP_OFS_SYS_STATUS: read_mux = sys_st;
      `SPDP_OFS_CRC_STATUS: read_mux = {5'h00, crc};
      default: read_mux = 8'h00;
    endcase
  endfunction

  // status view of the system domain
  logic [7:0] sys_status;
  always_comb begin
    sys_status = 8'h00;
    sys_status[`SPDP_BIT_RSTSYS] = st_r.rstsys;
    sys_status[`SPDP_BIT_INSLEEP] = sys_sleep_i;
    sys_status[`SPDP_BIT_PROG_RDY] = prog_ready_i;
    sys_status[`SPDP_BIT_UROW_RDY] = urow_ready_i;
    sys_status[`SPDP_BIT_LOCKED] = dev_locked_i;
  end

  // next state of the whole bank
  always_comb begin
    logic wr;
    logic rd;
    logic bit_tick;
    logic par_err;
    logic coll_err;
    logic [2:0] new_err;
    wr = acc_i.wr;
    rd = acc_i.rd;
    bit_tick = 1'b0;
    par_err = 1'b0;
    coll_err = 1'b0;
    new_err = `SPDP_ERR_NONE;
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.timeout = 1'b0;
    st_nxt.phy_rst = 1'b0;
    st_nxt.urow_final = 1'b0;
    st_nxt.nack = 1'b0;

    // bit tick divider; restarts with each spacing period
    if (st_r.div_cnt == DW'(BAUD_DIV - 1) || st_r.tx_st == SPDP_TX_IDLE) begin
      st_nxt.div_cnt = '0;
      bit_tick = st_r.tx_st != SPDP_TX_IDLE;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 1'b1;
    end

    // error detection: contention first, then timeout, start, frame, parity
    par_err = err_i.parity && !st_r.ctrl_pri[`SPDP_BIT_PARITY_IGN];
    coll_err = err_i.contention && tx_active_i && !st_r.coll_off;
    if (coll_err) begin
      new_err = `SPDP_ERR_CONTENTION;
    end else if (st_r.timeout) begin
      new_err = `SPDP_ERR_TIMEOUT;
    end else if (err_i.start) begin
      new_err = `SPDP_ERR_START;
    end else if (err_i.frame) begin
      new_err = `SPDP_ERR_FRAME;
    end else if (par_err) begin
      new_err = `SPDP_ERR_PARITY;
    end

    // access layer response watchdog
    if (resp_wait_i && !acc_resp_i && !st_r.ctrl_pri[`SPDP_BIT_TMO_OFF]) begin
      if (st_r.tmo_cnt == TW'(TIMEOUT_CYCLES - 1)) begin
        st_nxt.timeout = 1'b1;
        st_nxt.tmo_cnt = '0;
      end else begin
        st_nxt.tmo_cnt = st_r.tmo_cnt + 1'b1;
      end
    end else begin
      st_nxt.tmo_cnt = '0;
    end

    // transmitter spacing machine
    case (st_r.tx_st)
      SPDP_TX_IDLE: begin
        if (rx_to_tx_i && st_r.ctrl_pri[`SPDP_GUARD_HI:0] != `SPDP_GUARD_OFF) begin
          st_nxt.tx_st = SPDP_TX_GUARD;
          st_nxt.gap_cnt = guard_bits(st_r.ctrl_pri[`SPDP_GUARD_HI:0]);
        end else if (tx_byte_done_i && multi_byte_i && st_r.ctrl_pri[`SPDP_BIT_INTER_BYTE_DELAY_EN]) begin
          st_nxt.tx_st = SPDP_TX_GAP;
          st_nxt.gap_cnt = 8'(GAP_BITS);
        end
      end
      SPDP_TX_GUARD, SPDP_TX_GAP: begin
        if (bit_tick) begin
          st_nxt.gap_cnt = st_r.gap_cnt - 1'b1;
          if (st_r.gap_cnt == 8'h01) begin
            st_nxt.tx_st = SPDP_TX_IDLE;
          end
        end
      end
      default: st_nxt.tx_st = SPDP_TX_IDLE;
    endcase

    // nack on a system reset during a load or store
    st_nxt.nack = nack_req_i && !st_r.nack_off;

    // key activation; program and erase keys clear at sequence end, user row key by write
    if (key_urow_set_i) begin
      st_nxt.keys[2] = 1'b1;
    end else if (wr && acc_i.addr == `SPDP_OFS_KEY_STATUS && acc_i.wdata[`SPDP_BIT_KEY_UROW]) begin
      st_nxt.keys[2] = 1'b0;
    end
    if (key_prog_set_i) begin
      st_nxt.keys[1] = 1'b1;
    end else if (prog_done_i) begin
      st_nxt.keys[1] = 1'b0;
    end
    if (key_erase_set_i) begin
      st_nxt.keys[0] = 1'b1;
    end else if (erase_done_i) begin
      st_nxt.keys[0] = 1'b0;
    end

    // register reads and their side effects; a new event beats the clear
    if (rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = read_mux(st_r, acc_i.addr, sys_status, crc_status_i);
      if (acc_i.addr == `SPDP_OFS_ERR_STATUS) begin
        st_nxt.err_sig = `SPDP_ERR_NONE;
      end
      if (acc_i.addr == `SPDP_OFS_SYS_STATUS) begin
        st_nxt.rstsys = 1'b0;
      end
    end
    if (new_err != `SPDP_ERR_NONE) begin
      st_nxt.err_sig = new_err;
    end
    if (sys_reset_active_i || st_r.rst_held) begin
      st_nxt.rstsys = 1'b1;
    end

    // register writes; reserved bits are dropped
    if (wr) begin
      case (acc_i.addr)
        `SPDP_OFS_CTRL_PRI: st_nxt.ctrl_pri = acc_i.wdata & `SPDP_CTRL_PRI_MASK;
        `SPDP_OFS_CTRL_SEC: begin
          st_nxt.nack_off = acc_i.wdata[`SPDP_BIT_NACK_OFF];
          st_nxt.coll_off = acc_i.wdata[`SPDP_BIT_COLL_OFF];
        end
        `SPDP_OFS_RST_REQ: st_nxt.rst_held = acc_i.wdata == `SPDP_RESET_SIGNATURE;
        `SPDP_OFS_SYS_CTRL: begin
          st_nxt.clk_req = acc_i.wdata[`SPDP_BIT_SYSTEM_CLOCK_REQUEST];
          st_nxt.urow_final = acc_i.wdata[`SPDP_BIT_UROW_FINAL] && st_r.keys[2];
        end
        default: ;
      endcase
    end

    // port disable: back to defaults, keys and clock request dropped
    if (wr && acc_i.addr == `SPDP_OFS_CTRL_SEC && acc_i.wdata[`SPDP_BIT_PORT_DIS]) begin
      st_nxt.ctrl_pri = `SPDP_RST_CTRL_PRI;
      st_nxt.nack_off = 1'b0;
      st_nxt.coll_off = 1'b0;
      st_nxt.err_sig = `SPDP_ERR_NONE;
      st_nxt.keys = 3'b000;
      st_nxt.clk_req = 1'b0;
      st_nxt.tx_st = SPDP_TX_IDLE;
      st_nxt.gap_cnt = 8'h00;
      st_nxt.tmo_cnt = '0;
      st_nxt.port_off = 1'b1;
      st_nxt.phy_rst = 1'b1;
    end else if (st_r.port_off && link_wake_i) begin
      // a fresh link attempt enables the port with the clock requested
      st_nxt.port_off = 1'b0;
      st_nxt.clk_req = 1'b1;
    end
  end

  // state register; the system reset held from the bank does not reset the bank itself
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.ctrl_pri <= `SPDP_RST_CTRL_PRI;
      st_r.clk_req <= 1'b1;
      st_r.tx_st <= SPDP_TX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign acc_rdata_o = st_r.rdata;
  assign acc_rvalid_o = st_r.rvalid;
  assign tx_hold_o = st_r.tx_st != SPDP_TX_IDLE;
  assign parity_check_en_o = !st_r.ctrl_pri[`SPDP_BIT_PARITY_IGN];
  assign resp_sig_en_o = !st_r.ctrl_pri[`SPDP_BIT_RSIG_OFF];
  assign collision_detect_en_o = !st_r.coll_off;
  assign nack_send_o = st_r.nack;
  assign timeout_o = st_r.timeout;
  assign phy_enable_o = !st_r.port_off;
  assign phy_reset_o = st_r.phy_rst;
  assign sys_reset_req_o = st_r.rst_held;
  assign sys_clock_req_o = st_r.clk_req && !st_r.port_off;
  assign urow_final_o = st_r.urow_final;
  assign key_status_o = st_r.keys;

endmodule // spdp_bank

/* File: rtl/spdp_pkg.sv */
// types shared by the debug port register bank
// assumes spdp_regs.svh sits beside it
package spdp_pkg;
  `include "spdp_regs.svh"
  // register access from the link instruction decoder
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } spdp_acc_type;
  // error events raised by the physical layer
  typedef struct packed {
    logic parity;
    logic frame;
    logic start;
    logic contention;
  } spdp_err_type;
  // spacing machine of the transmitter
  typedef enum logic [1:0] {
    SPDP_TX_IDLE = 2'b00,
    SPDP_TX_GUARD = 2'b01,
    SPDP_TX_GAP = 2'b10
  } spdp_tx_type;
endpackage

/* File: rtl/spdp_regs.svh */
// register offsets, field positions, reset values and codes of the debug port register bank
// assumes it is included by its bare name from the package, which the bank module imports
`ifndef SPDP_REGS_SVH
`define SPDP_REGS_SVH
// offsets within the debug register space
`define SPDP_OFS_REV_STATUS 4'h0
`define SPDP_OFS_ERR_STATUS 4'h1
`define SPDP_OFS_CTRL_PRI 4'h2
`define SPDP_OFS_CTRL_SEC 4'h3
`define SPDP_OFS_KEY_STATUS 4'h7
`define SPDP_OFS_RST_REQ 4'h8
`define SPDP_OFS_CLK_CTRL 4'h9
`define SPDP_OFS_SYS_CTRL 4'ha
`define SPDP_OFS_SYS_STATUS 4'hb
`define SPDP_OFS_CRC_STATUS 4'hc
// field positions
`define SPDP_BIT_INTER_BYTE_DELAY_EN 7
`define SPDP_BIT_PARITY_IGN 5
`define SPDP_BIT_TMO_OFF 4
`define SPDP_BIT_RSIG_OFF 3
`define SPDP_BIT_NACK_OFF 4
`define SPDP_BIT_COLL_OFF 3
`define SPDP_BIT_PORT_DIS 2
`define SPDP_BIT_KEY_UROW 5
`define SPDP_BIT_KEY_PROG 4
`define SPDP_BIT_KEY_ERASE 3
`define SPDP_BIT_SYSTEM_CLOCK_REQUEST 0
`define SPDP_BIT_UROW_FINAL 1
`define SPDP_BIT_RSTSYS 5
`define SPDP_BIT_INSLEEP 4
`define SPDP_BIT_PROG_RDY 3
`define SPDP_BIT_UROW_RDY 2
`define SPDP_BIT_LOCKED 0
`define SPDP_BIT_RST_HELD 0
`define SPDP_GUARD_HI 2
// writable bits of the primary control register; bit 6 is reserved
`define SPDP_CTRL_PRI_MASK 8'hbf
// reset values and constants
`define SPDP_RST_CTRL_PRI 8'h00
`define SPDP_RESET_SIGNATURE 8'h59
`define SPDP_GUARD_OFF 3'h7
`define SPDP_GUARD_BASE 8'h80
`define SPDP_IDLE_CHARS 2
`define SPDP_CHAR_BITS 12
`define SPDP_TIMEOUT_CYCLES 65536
// error signature codes
`define SPDP_ERR_NONE 3'h0
`define SPDP_ERR_PARITY 3'h1
`define SPDP_ERR_FRAME 3'h2
`define SPDP_ERR_TIMEOUT 3'h3
`define SPDP_ERR_START 3'h4
`define SPDP_ERR_CONTENTION 3'h7
`endif

/* File: tb/spdp_bank_assertions.sv */
// port assertions of the debug port register bank
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module spdp_bank_assertions
  import spdp_pkg::*;
#(
  parameter logic [3:0] PORT_REV = 4'h3 // must match the bank instance
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // register access
  input wire spdp_acc_type acc_i,
  input wire logic [7:0] acc_rdata_o,
  input wire logic acc_rvalid_o,
  // events and controls
  input wire logic nack_req_i,
  input wire logic parity_check_en_o,
  input wire logic resp_sig_en_o,
  input wire logic collision_detect_en_o,
  input wire logic nack_send_o,
  input wire logic phy_enable_o,
  input wire logic phy_reset_o,
  input wire logic sys_reset_req_o,
  input wire logic sys_clock_req_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // writes while disabled are left out of the control, collision and clock checks, since the off state is a design choice
  chk_read_answer: assert property (acc_i.rd |=> acc_rvalid_o)
    else $error("read not answered");
  chk_no_stray: assert property (!acc_i.rd |=> !acc_rvalid_o)
    else $error("answer without read");
  chk_rev_field: assert property (acc_i.rd && acc_i.addr == 4'h0 |=> acc_rdata_o == {PORT_REV, 4'h0})
    else $error("revision read wrong");
  chk_reserved_zero: assert property (acc_i.rd && (acc_i.addr inside {4'h4, 4'h5, 4'h6, 4'h9}) |=> acc_rdata_o == 8'h00)
    else $error("reserved read not zero");
  chk_err_width: assert property (acc_i.rd && acc_i.addr == 4'h1 |=> acc_rdata_o[7:3] == 5'h00)
    else $error("error status upper bits set");
  chk_ctrl_follow: assert property (acc_i.wr && acc_i.addr == 4'h2 && phy_enable_o |=>
    parity_check_en_o != $past(acc_i.wdata[5]) && resp_sig_en_o != $past(acc_i.wdata[3]))
    else $error("primary control not applied");
  chk_coll_follow: assert property (acc_i.wr && acc_i.addr == 4'h3 && !acc_i.wdata[2] && phy_enable_o |=>
    collision_detect_en_o != $past(acc_i.wdata[3]))
    else $error("collision control not applied");
  chk_port_off: assert property (acc_i.wr && acc_i.addr == 4'h3 && acc_i.wdata[2] |=>
    !phy_enable_o && phy_reset_o && !sys_clock_req_o && parity_check_en_o)
    else $error("port disable incomplete");
  chk_rst_sig: assert property (acc_i.wr && acc_i.addr == 4'h8 |=> sys_reset_req_o == ($past(acc_i.wdata) == 8'h59))
    else $error("reset request wrong");
  chk_clk_req: assert property (acc_i.wr && acc_i.addr == 4'ha && phy_enable_o |=> sys_clock_req_o == $past(acc_i.wdata[0]))
    else $error("clock request wrong");
  chk_nack_cause: assert property (nack_send_o |-> $past(nack_req_i))
    else $error("negative ack without cause");
endmodule // spdp_bank_assertions

bind spdp_bank spdp_bank_assertions #(.PORT_REV(PORT_REV)) spdp_bank_assertions_i (.clock_i, .srst_i, .acc_i,
  .acc_rdata_o, .acc_rvalid_o, .nack_req_i, .parity_check_en_o, .resp_sig_en_o, .collision_detect_en_o,
  .nack_send_o, .phy_enable_o, .phy_reset_o, .sys_reset_req_o, .sys_clock_req_o);

/* File: tb/spdp_dbg_model.sv */
// debugger side model: issues register accesses through link instructions
// assumes requests change on falling edges and are taken on the next rising edge
`timescale 1ns/1ps
module spdp_dbg_model
  import spdp_pkg::*;
(
  // clock
  input wire logic clock_i,
  // request towards the bank
  output spdp_acc_type acc_o,
  // answer from the bank
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial acc_o = '0;
  // one write held over one taking edge; released bus shows inverted values
  task automatic write_reg(input logic [3:0] a, input logic [7:0] v);
    @(negedge clock_i);
    acc_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(negedge clock_i);
    acc_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
  endtask
  // one read; the answer stands for the cycle after the taking edge
  task automatic read_reg(input logic [3:0] a, output logic [7:0] v, output logic ok);
    @(negedge clock_i);
    acc_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock_i);
    v = rdata_i;
    ok = rvalid_i;
    acc_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
endmodule // spdp_dbg_model

/* File: tb/tb_spdp_bank.sv */
// self-checking bench of the debug port register bank
// assumes the debugger model drives accesses and all events change on falling edges
`timescale 1ns/1ps
module tb_spdp_bank
  import spdp_pkg::*;
;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  spdp_acc_type acc;
  logic [7:0] rdata, d;
  logic rvalid, ok, tx_hold, par_en, rsig_en, coll_en, nack_send, tmo, phy_en, phy_rst, rst_req, clk_req, ufin;
  logic [2:0] keys;
  logic [13:0] ev = 14'h0000; // one-cycle event pulses, indexed by pulse()
  logic tx_active = 1'b0;
  logic multi = 1'b0;
  logic resp_wait = 1'b0;
  logic [4:0] lvl = 5'h00; // reset active, sleep, prog ready, urow ready, locked
  logic [2:0] crc = 3'h4;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  localparam int BD = 2; // short bit period keeps guard runs brief
  always #5 clock_i = ~clock_i;
  spdp_bank #(.BAUD_DIV(BD), .TIMEOUT_CYCLES(40)) spdp_bank_i (.clock_i(clock_i), .srst_i(srst_i), .acc_i(acc),
    .acc_rdata_o(rdata), .acc_rvalid_o(rvalid), .err_i({ev[0], ev[1], ev[2], ev[3]}), .tx_active_i(tx_active),
    .rx_to_tx_i(ev[4]), .tx_byte_done_i(ev[5]), .multi_byte_i(multi), .resp_wait_i(resp_wait), .acc_resp_i(ev[6]),
    .nack_req_i(ev[7]), .link_wake_i(ev[8]), .key_urow_set_i(ev[9]), .key_prog_set_i(ev[10]),
    .key_erase_set_i(ev[11]), .prog_done_i(ev[12]), .erase_done_i(ev[13]), .sys_reset_active_i(lvl[4]),
    .sys_sleep_i(lvl[3]), .prog_ready_i(lvl[2]), .urow_ready_i(lvl[1]), .dev_locked_i(lvl[0]), .crc_status_i(crc),
    .tx_hold_o(tx_hold), .parity_check_en_o(par_en), .resp_sig_en_o(rsig_en), .collision_detect_en_o(coll_en),
    .nack_send_o(nack_send), .timeout_o(tmo), .phy_enable_o(phy_en), .phy_reset_o(phy_rst),
    .sys_reset_req_o(rst_req), .sys_clock_req_o(clk_req), .urow_final_o(ufin), .key_status_o(keys));
  spdp_dbg_model spdp_dbg_model_i (.clock_i(clock_i), .acc_o(acc), .rdata_i(rdata), .rvalid_i(rvalid));
  // value and flag comparisons
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    spdp_dbg_model_i.read_reg(a, d, ok);
    chk1(nm, 1'b1, ok);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    spdp_dbg_model_i.write_reg(a, v);
  endtask
  task automatic pulse(input int b);
    @(negedge clock_i);
    ev[b] = 1'b1;
    @(negedge clock_i);
    ev[b] = 1'b0;
  endtask
  // hold may start a cycle late, so allow a short lead-in before counting
  task automatic hold_len(output int c);
    c = 0;
    for (int k = 0; k < 4 && tx_hold !== 1'b1; k++) @(negedge clock_i);
    while (tx_hold === 1'b1 && c < 600) begin
      @(negedge clock_i);
      c++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    chk("dflt", 16'h00f8, {8'h00, par_en, rsig_en, coll_en, phy_en, clk_req, nack_send, rst_req, tmo});
    for (int i = 0; i < 16; i++) rchk("map", i[3:0], (i == 0) ? 8'h30 : (i == 10) ? 8'h01 : (i == 12) ? 8'h04 : 8'h00);
    wr(4'h0, 8'hff);
    rchk("rev_ro", 4'h0, 8'h30);
    wr(4'h2, 8'hff);
    rchk("ctrl_a", 4'h2, 8'hbf);
    wr(4'h3, 8'hfb);
    rchk("ctrl_b", 4'h3, 8'h18);
    chk("ctl_on", 16'h0000, {13'h0000, par_en, rsig_en, coll_en});
    $display("test registers done");
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    tx_active = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rchk("err_sig", 4'h1, (i == 3) ? 8'h07 : 8'h01 << i);
      rchk("err_clr", 4'h1, 8'h00);
    end
    wr(4'h2, 8'h20);
    pulse(0);
    rchk("par_ign", 4'h1, 8'h00);
    wr(4'h3, 8'h08);
    pulse(3);
    rchk("coll_off", 4'h1, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
    $display("test errors done");
    resp_wait = 1'b1;
    n = 0;
    while (tmo !== 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    resp_wait = 1'b0;
    chk1("tmo_time", 1'b1, n >= 38 && n <= 42);
    rchk("err_tmo", 4'h1, 8'h03);
    resp_wait = 1'b1;
    repeat (20) @(negedge clock_i);
    pulse(6);
    resp_wait = 1'b0;
    rchk("resp_ok", 4'h1, 8'h00);
    wr(4'h2, 8'h10);
    resp_wait = 1'b1;
    repeat (60) @(negedge clock_i);
    resp_wait = 1'b0;
    rchk("tmo_off", 4'h1, 8'h00);
    $display("test timeout done");
    for (int c = 0; c < 8; c++) begin
      wr(4'h2, {5'h00, c[2:0]});
      pulse(4);
      hold_len(n);
      chk("guard", (c == 7) ? 16'h0000 : 16'((16'h0080 >> c) * BD), n[15:0]);
    end
    multi = 1'b1;
    pulse(5);
    hold_len(n);
    chk("no_gap", 16'h0000, n[15:0]);
    wr(4'h2, 8'h87);
    pulse(5);
    hold_len(n);
    chk("gap", 16'h0030, n[15:0]);
    multi = 1'b0;
    $display("test spacing done");
    pulse(7);
    chk1("nack", 1'b1, nack_send);
    wr(4'h3, 8'h10);
    pulse(7);
    chk1("nack_off", 1'b0, nack_send);
    pulse(9);
    rchk("key_urow", 4'h7, 8'h20);
    pulse(10);
    rchk("key_prog", 4'h7, 8'h30);
    pulse(11);
    rchk("key_erase", 4'h7, 8'h38);
    chk("keys", 16'h0007, {13'h0000, keys});
    pulse(12);
    rchk("prog_done", 4'h7, 8'h28);
    pulse(13);
    rchk("erase_done", 4'h7, 8'h20);
    wr(4'h7, 8'h20);
    rchk("urow_clr", 4'h7, 8'h00);
    $display("test keys done");
    lvl = 5'h1f;
    rchk("sys_st", 4'hb, 8'h3d);
    lvl = 5'h00;
    // reset was still active at the first clearing read, so the sticky flag survives once
    rchk("sys_stk", 4'hb, 8'h20);
    rchk("sys_clr", 4'hb, 8'h00);
    wr(4'h8, 8'h59);
    chk1("rst_on", 1'b1, rst_req);
    rchk("rst_rd", 4'h8, 8'h01);
    wr(4'h8, 8'h58);
    chk1("rst_off", 1'b0, rst_req);
    wr(4'ha, 8'h00);
    chk1("clk_off", 1'b0, clk_req);
    wr(4'ha, 8'h01);
    chk1("clk_on", 1'b1, clk_req);
    $display("test system done");
    pulse(9);
    wr(4'ha, 8'h03);
    chk1("ufinal", 1'b1, ufin);
    wr(4'h2, 8'h33);
    wr(4'h3, 8'h04);
    chk1("phy_rst", 1'b1, phy_rst);
    chk("dis", 16'h0038, {8'h00, phy_en, clk_req, par_en, rsig_en, coll_en, keys});
    pulse(8);
    chk("wake", 16'h0003, {14'h0000, phy_en, clk_req});
    rchk("ctrl_rst", 4'h2, 8'h00);
    rchk("key_rst", 4'h7, 8'h00);
    $display("test disable done");
    stop_test();
  end
  // hang guard, far beyond the roughly nine hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    stop_test();
  end
endmodule // tb_spdp_bank
